// File: rtl/wakeup_line_map.svh
`ifndef WAKEUP_LINE_MAP_SVH
`define WAKEUP_LINE_MAP_SVH

`define NUM_LINES 16
`define HALF_LINES 8
`define REG_WIDTH 8
`define ADDR_WIDTH 12
`define DATA_WIDTH 32

`define OFF_SOFT_PENDING 12'h01C
`define OFF_CONTROL 12'h024
`define OFF_MASK_HIGH 12'h028
`define OFF_MASK_LOW 12'h02C
`define OFF_POL_HIGH 12'h030
`define OFF_POL_LOW 12'h034
`define OFF_PEND_HIGH 12'h038
`define OFF_PEND_LOW 12'h03C

`define RST_SOFT_PENDING 8'h00
`define RST_CONTROL 8'h00
`define RST_MASK 8'h00
`define RST_POL 8'h00
`define RST_PEND 8'h00

`define CTRL_WAKEUP_SELECT 0
`define CTRL_GLOBAL_ENABLE 1
`define CTRL_STOP 2

`endif

// File: rtl/wakeup_line_pkg.sv
`include "wakeup_line_map.svh"

package wakeup_line_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`ADDR_WIDTH-1:0] paddr;
        logic [`DATA_WIDTH-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [`DATA_WIDTH-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ONE = 2'h1,
        ST_ONE_ZERO = 2'h3,
        ST_STOPPED = 2'h2
    } stop_state_t;

endpackage

// File: rtl/line_edge_detect.sv
`timescale 1ns/1ps
`include "wakeup_line_map.svh"

module line_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`NUM_LINES-1:0] lines,
    input wire logic [`NUM_LINES-1:0] polarity,
    input wire logic arm,
    output logic [`NUM_LINES-1:0] edge_seen,
    output logic [`NUM_LINES-1:0] caught
);
    genvar i;
    generate
        for (i = 0; i < `NUM_LINES; i++) begin : g_line
            logic meta;
            logic sync;
            logic prev;
            logic trig;
            logic held;
            logic held_meta;
            logic held_sync;
            logic held_prev;
            logic arm_n;
            // Two-flop synchroniser, then a delay flop for edge detection
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    meta <= lines[i];
                    sync <= meta;
                    prev <= sync;
                end
            end
            // Catches the active edge with no pclk running
            assign trig = ~(lines[i] ^ polarity[i]);
            assign arm_n = presetn & arm;
            always_ff @(posedge trig or negedge arm_n) begin
                if (!arm_n) begin
                    held <= 1'b0;
                end else begin
                    held <= 1'b1;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    held_meta <= 1'b0;
                    held_sync <= 1'b0;
                    held_prev <= 1'b0;
                end else begin
                    held_meta <= held;
                    held_sync <= held_meta;
                    held_prev <= held_sync;
                end
            end
            assign caught[i] = held;
            assign edge_seen[i] = (polarity[i] ? (sync & ~prev) : (~sync & prev))
                | (held_sync & ~held_prev);
        end
    endgenerate
endmodule

// File: rtl/stop_sequencer.sv
`timescale 1ns/1ps
`include "wakeup_line_map.svh"

module stop_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ctrl_write,
    input wire logic stop_value,
    input wire logic entry_ok,
    input wire logic wake_now,
    output wakeup_line_pkg::stop_state_t state
);
    import wakeup_line_pkg::*;

    stop_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ctrl_write && stop_value) begin
                    next_state = ST_ONE;
                end
            end
            ST_ONE: begin
                if (ctrl_write && !stop_value) begin
                    next_state = ST_ONE_ZERO;
                end
            end
            ST_ONE_ZERO: begin
                if (ctrl_write) begin
                    if (stop_value && entry_ok) begin
                        next_state = ST_STOPPED;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_STOPPED: begin
                if (wake_now) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Control writes, and a wake-up while stopped, move the tracker; other traffic leaves it waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end
endmodule

// File: rtl/wakeup_line_controller.sv
// Summary of operation
// - Stop entry needs writes 1, 0, 1 to stop bit; other accesses may interleave.
// - A correct sequence sets the stop bit and raises the stop request.
// - Success needs wake-up select, no unmasked pending, at least one mask bit set.
// - While stopped, an unmasked wake-up event clears the stop bit.
// - Stop bit reads 1 after first write of 1 and after success only.
// - Interrupt mid-sequence leaves the partial sequence waiting for its writes.
// - Two writes of 0 return the tracker to idle.
// - Wake-up event during the sequence blocks stop; its pending bit stays.
// - Any one of 16 unmasked lines leaves stop.
// - Pending bits are edge set; clearing under a held level stays cleared.
// - Eight software interrupt bits raise interrupts, gated by global enable.
// - Control bit 1 is the global interrupt enable.
// - Control bit 0 selects wake-up source use; interrupt routing does not depend on it.
// - Mask and pending: enable gates interrupt, select gates wake-up event.
// - A masked line never produces a wake-up event.
// - Polarity 0 sets pending on falling edge, 1 on rising edge.
// - Mask and polarity split into high 15:8 and low 7:0 registers.
// - Hardware sets pending bits; software clears by writing 0 only.
// - Edge during a polarity register write does not set pending.
// - Clearing one pending bit with another left gives a fresh request edge.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "wakeup_line_map.svh"

module wakeup_line_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wakeup_line_pkg::apb_req_t apb_in,
    output wakeup_line_pkg::apb_rsp_t apb_out,
    input wire logic [`NUM_LINES-1:0] wake_lines,
    output logic irq_request,
    output logic wake_event,
    output logic stop_request,
    output logic async_wake
);
    import wakeup_line_pkg::*;

    logic [`REG_WIDTH-1:0] soft_interrupt_pending;
    logic global_interrupt_enable;
    logic wakeup_select;
    logic [`REG_WIDTH-1:0] line_mask_high;
    logic [`REG_WIDTH-1:0] line_mask_low;
    logic [`REG_WIDTH-1:0] trigger_polarity_high;
    logic [`REG_WIDTH-1:0] trigger_polarity_low;
    logic [`NUM_LINES-1:0] line_pending;

    logic [`NUM_LINES-1:0] line_mask;
    logic [`NUM_LINES-1:0] trigger_polarity;
    logic [`NUM_LINES-1:0] edge_seen;
    logic [`NUM_LINES-1:0] caught;
    logic [`NUM_LINES-1:0] set_pending;
    logic [`NUM_LINES-1:0] clear_pending;
    logic [`NUM_LINES-1:0] next_pending;
    logic [`REG_WIDTH-1:0] wdata;
    logic setup;
    logic access;
    logic wr;
    logic wr_soft;
    logic wr_ctrl;
    logic wr_mask_high;
    logic wr_mask_low;
    logic wr_pol_high;
    logic wr_pol_low;
    logic wr_pend_high;
    logic wr_pend_low;
    logic pol_write;
    logic unmasked_any;
    logic wake_now;
    logic entry_ok;
    logic stop_bit;
    logic clear_blip;
    logic arm;
    stop_state_t state;

    // Reset image of the control register, so single bits can be picked out
    localparam logic [`REG_WIDTH-1:0] reset_control = `RST_CONTROL;

    function automatic logic hit(
        input logic [`ADDR_WIDTH-1:0] addr,
        input logic [`ADDR_WIDTH-1:0] offset
    );
        hit = (addr == offset);
    endfunction

    function automatic logic mapped(input logic [`ADDR_WIDTH-1:0] addr);
        mapped = hit(addr, `OFF_SOFT_PENDING) || hit(addr, `OFF_CONTROL)
            || hit(addr, `OFF_MASK_HIGH) || hit(addr, `OFF_MASK_LOW)
            || hit(addr, `OFF_POL_HIGH) || hit(addr, `OFF_POL_LOW)
            || hit(addr, `OFF_PEND_HIGH) || hit(addr, `OFF_PEND_LOW);
    endfunction

    // Bus phases: registers change only at the completing access edge
    assign setup = apb_in.psel & ~apb_in.penable;
    assign access = apb_in.psel & apb_in.penable & apb_out.pready;
    assign wr = access & apb_in.pwrite & mapped(apb_in.paddr);
    assign wdata = apb_in.pwdata[`REG_WIDTH-1:0];

    assign wr_soft = wr & hit(apb_in.paddr, `OFF_SOFT_PENDING);
    assign wr_ctrl = wr & hit(apb_in.paddr, `OFF_CONTROL);
    assign wr_mask_high = wr & hit(apb_in.paddr, `OFF_MASK_HIGH);
    assign wr_mask_low = wr & hit(apb_in.paddr, `OFF_MASK_LOW);
    assign wr_pol_high = wr & hit(apb_in.paddr, `OFF_POL_HIGH);
    assign wr_pol_low = wr & hit(apb_in.paddr, `OFF_POL_LOW);
    assign wr_pend_high = wr & hit(apb_in.paddr, `OFF_PEND_HIGH);
    assign wr_pend_low = wr & hit(apb_in.paddr, `OFF_PEND_LOW);
    assign pol_write = wr_pol_high | wr_pol_low;

    assign line_mask = {line_mask_high, line_mask_low};
    assign trigger_polarity = {trigger_polarity_high, trigger_polarity_low};

    line_edge_detect u_edges (
        .pclk(pclk),
        .presetn(presetn),
        .lines(wake_lines),
        .polarity(trigger_polarity),
        .arm(arm),
        .edge_seen(edge_seen),
        .caught(caught)
    );

    // Qualifying edges; a polarity write in the same cycle swallows them
    assign set_pending = pol_write ? '0 : edge_seen;

    always_comb begin
        clear_pending = '0;
        if (wr_pend_high) begin
            clear_pending[`NUM_LINES-1:`HALF_LINES] = ~wdata;
        end
        if (wr_pend_low) begin
            clear_pending[`HALF_LINES-1:0] = ~wdata;
        end
    end

    // A new edge wins over a clear in the same cycle
    assign next_pending = (line_pending & ~clear_pending) | set_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_pending <= {`RST_PEND, `RST_PEND};
        end else begin
            line_pending <= next_pending;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_interrupt_pending <= `RST_SOFT_PENDING;
        end else if (wr_soft) begin
            soft_interrupt_pending <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_interrupt_enable <= reset_control[`CTRL_GLOBAL_ENABLE];
            wakeup_select <= reset_control[`CTRL_WAKEUP_SELECT];
        end else if (wr_ctrl) begin
            global_interrupt_enable <= wdata[`CTRL_GLOBAL_ENABLE];
            wakeup_select <= wdata[`CTRL_WAKEUP_SELECT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_mask_high <= `RST_MASK;
        end else if (wr_mask_high) begin
            line_mask_high <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_mask_low <= `RST_MASK;
        end else if (wr_mask_low) begin
            line_mask_low <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_polarity_high <= `RST_POL;
        end else if (wr_pol_high) begin
            trigger_polarity_high <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_polarity_low <= `RST_POL;
        end else if (wr_pol_low) begin
            trigger_polarity_low <= wdata;
        end
    end

    // Any unmasked pending line counts; wake_now and entry_ok also count an edge landing this cycle
    assign unmasked_any = |(line_mask & line_pending);
    assign wake_now = wakeup_select & |(line_mask & next_pending);

    assign entry_ok = wakeup_select & (|line_mask)
        & ~(|(line_mask & next_pending));

    stop_sequencer u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ctrl_write(wr_ctrl),
        .stop_value(wdata[`CTRL_STOP]),
        .entry_ok(entry_ok),
        .wake_now(wake_now),
        .state(state)
    );

    assign stop_bit = (state == ST_ONE) || (state == ST_STOPPED);

    // One low cycle after a clear lets the request rise again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_blip <= 1'b0;
        end else begin
            clear_blip <= |(clear_pending & line_pending);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= global_interrupt_enable & ~clear_blip
                & (unmasked_any | (|soft_interrupt_pending));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_event <= 1'b0;
        end else begin
            wake_event <= wakeup_select & unmasked_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_request <= 1'b0;
        end else begin
            stop_request <= (state == ST_STOPPED) && !wake_now;
        end
    end

    // Clockless catch is armed only in stop, so polarity writes cannot glitch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm <= 1'b0;
        end else begin
            arm <= (state == ST_STOPPED) && wakeup_select;
        end
    end

    // Combinational so it still works with pclk halted
    assign async_wake = arm & |(caught & line_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_out.pready <= 1'b0;
        end else begin
            apb_out.pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_out.pslverr <= 1'b0;
        end else begin
            apb_out.pslverr <= setup & ~mapped(apb_in.paddr);
        end
    end

    // Read data is sampled in the setup cycle and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_out.prdata <= '0;
        end else if (setup) begin
            apb_out.prdata <= '0;
            if (!apb_in.pwrite) begin
                case (apb_in.paddr)
                    `OFF_SOFT_PENDING: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= soft_interrupt_pending;
                    end
                    `OFF_CONTROL: begin
                        apb_out.prdata[`CTRL_STOP] <= stop_bit;
                        apb_out.prdata[`CTRL_GLOBAL_ENABLE] <= global_interrupt_enable;
                        apb_out.prdata[`CTRL_WAKEUP_SELECT] <= wakeup_select;
                    end
                    `OFF_MASK_HIGH: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= line_mask_high;
                    end
                    `OFF_MASK_LOW: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= line_mask_low;
                    end
                    `OFF_POL_HIGH: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= trigger_polarity_high;
                    end
                    `OFF_POL_LOW: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= trigger_polarity_low;
                    end
                    `OFF_PEND_HIGH: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <=
                            line_pending[`NUM_LINES-1:`HALF_LINES];
                    end
                    `OFF_PEND_LOW: begin
                        apb_out.prdata[`REG_WIDTH-1:0] <= line_pending[`HALF_LINES-1:0];
                    end
                    default: begin
                        apb_out.prdata <= '0;
                    end
                endcase
            end
        end
    end
endmodule

// File: bench/wakeup_line_checker_props.sv
`timescale 1ns/1ps
`include "wakeup_line_map.svh"
module wakeup_line_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wakeup_line_pkg::apb_req_t apb_in,
    input wakeup_line_pkg::apb_rsp_t apb_out,
    input wire logic wake_event,
    input wire logic stop_request,
    input wire logic async_wake
);
    import wakeup_line_pkg::*;
    logic setup;
    logic ctl;
    logic stop_wr;
    logic mapped;
    assign setup = apb_in.psel & ~apb_in.penable;
    assign ctl = apb_in.paddr == `OFF_CONTROL;
    assign stop_wr = apb_in.psel & apb_in.penable & apb_in.pwrite & ctl
        & apb_in.pwdata[`CTRL_STOP];
    assign mapped = apb_in.paddr inside {`OFF_SOFT_PENDING, `OFF_CONTROL, `OFF_MASK_HIGH,
        `OFF_MASK_LOW, `OFF_POL_HIGH, `OFF_POL_LOW, `OFF_PEND_HIGH, `OFF_PEND_LOW};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_ready_pulse;
        apb_out.pready ##1 !apb_out.pready;
    endsequence
    sequence s_wake_in_stop;
        stop_request && async_wake;
    endsequence
    chk_ready_pulse: assert property (setup |=> s_ready_pulse)
        else $error("pready is not one pulse after setup");
    chk_slverr_map: assert property (apb_out.pready |-> apb_out.pslverr == !mapped)
        else $error("pslverr does not follow the address map");
    chk_ctrl_reserved: assert property (
        apb_out.pready && ctl && !apb_in.pwrite |-> apb_out.prdata[31:3] == 29'h0)
        else $error("control reserved bits read nonzero");
    chk_stop_cause: assert property (
        $rose(stop_request) |-> $past(stop_wr) || $past(stop_wr, 2))
        else $error("stop request without a stop write");
    chk_stop_blocked: assert property ($rose(stop_request) |-> !$past(wake_event))
        else $error("stop entered with a wake event present");
    chk_stop_exit: assert property ($fell(stop_request) |-> ##1 wake_event)
        else $error("stop left without a wake event");
    chk_stop_leave: assert property (s_wake_in_stop |-> ##[0:4] !stop_request)
        else $error("stop held despite a wake event");
    chk_stop_read: assert property (
        apb_out.pready && ctl && !apb_in.pwrite && stop_request && $past(stop_request, 2)
        |-> apb_out.prdata[`CTRL_STOP])
        else $error("stop bit reads 0 while stopped");
    chk_async_gate: assert property (
        async_wake |-> stop_request || $past(stop_request))
        else $error("clockless wake outside stop");
endmodule
bind wakeup_line_controller wakeup_line_checker wakeup_line_checker_inst (
    .pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
    .wake_event(wake_event), .stop_request(stop_request), .async_wake(async_wake));

// File: bench/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_request,
    input wire logic stop_request,
    output int irq_edges,
    output int stop_entries
);
    logic irq_q;
    logic stop_q;
    // Interrupt controller sets its pending flag on each rising request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            irq_edges <= 0;
        end else begin
            irq_q <= irq_request;
            irq_edges <= irq_edges + int'(irq_request & ~irq_q);
        end
    end
    // Clock unit acts once on each stop request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
            stop_entries <= 0;
        end else begin
            stop_q <= stop_request;
            stop_entries <= stop_entries + int'(stop_request & ~stop_q);
        end
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "wakeup_line_map.svh"
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("BAD %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb_top;
    import wakeup_line_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t apb_in = '0;
    apb_rsp_t apb_out;
    logic [`NUM_LINES-1:0] wake_lines = '0;
    logic irq_request;
    logic wake_event;
    logic stop_request;
    logic async_wake;
    int miscompares = 0;
    int cmp_count = 0;
    int irq_edges;
    int stop_entries;
    int l;
    logic [15:0] seed = 16'h72F5;
    logic [15:0] mm;
    logic [31:0] q;
    logic err;
    logic pol;
    logic [11:0] pa;
    logic [11:0] regs [8] = '{`OFF_SOFT_PENDING, `OFF_MASK_HIGH, `OFF_MASK_LOW,
        `OFF_POL_HIGH, `OFF_POL_LOW, `OFF_CONTROL, `OFF_PEND_HIGH, `OFF_PEND_LOW};

    always #5 pclk = ~pclk;

    wakeup_line_controller wakeup_line_controller_inst (.pclk(pclk), .presetn(presetn),
        .apb_in(apb_in), .apb_out(apb_out), .wake_lines(wake_lines),
        .irq_request(irq_request), .wake_event(wake_event), .stop_request(stop_request),
        .async_wake(async_wake));
    far_side_model far_side_model_inst (.pclk(pclk), .presetn(presetn),
        .irq_request(irq_request), .stop_request(stop_request), .irq_edges(irq_edges),
        .stop_entries(stop_entries));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected {irq_request, wake_event} with one unmasked pending line
    function automatic logic [1:0] exp_out(input logic [1:0] c, input logic hit);
        return {c[`CTRL_GLOBAL_ENABLE] & hit, c[`CTRL_WAKEUP_SELECT] & hit};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
        int n;
        @(posedge pclk);
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        apb_in.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_out.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
        end
        q = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wr(a, 32'h0, 1'b0);
        `CHK($sformatf("reg %h", a), e, q)
    endtask

    task automatic both(input logic [11:0] hi, input logic [15:0] v);
        wr(hi, {24'h0, v[15:8]});
        wr(hi + 12'h004, {24'h0, v[7:0]});
    endtask

    task automatic line(input int n, input logic v);
        @(posedge pclk);
        wake_lines[n] <= v;
        repeat (6) @(posedge pclk);
    endtask

    task automatic outs(input logic [1:0] e);
        repeat (2) @(posedge pclk);
        `CHK("irq_wake", e, {irq_request, wake_event})
    endtask

    // Writes stop bit values b (msb first) to control with low bits c
    task automatic wseq(input int n, input logic [3:0] b, input logic [1:0] c);
        for (int i = n - 1; i >= 0; i--) begin
            wr(`OFF_CONTROL, {29'h0, b[i], c});
        end
        repeat (6) @(posedge pclk);
    endtask

    task automatic stop3(input logic [1:0] c, input logic e);
        wseq(3, 4'h5, c);
        `CHK("stop_request", e, stop_request)
        rd(`OFF_CONTROL, {29'h0, e, c});
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rd(regs[k], 32'h0);
        end
        wr(12'h040, 32'h000000FF);
        rd(12'h040, 32'h0);
        `CHK("pslverr", 1'b1, err)
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            wr(regs[k], {seed, seed});
            rd(regs[k], {24'h0, seed[7:0]});
        end
        wr(`OFF_PEND_HIGH, 32'h000000FF);
        rd(`OFF_PEND_HIGH, 32'h0);
        wr(`OFF_SOFT_PENDING, 32'h00000081);
        wr(`OFF_CONTROL, 32'h0);
        outs(2'b00);
        wr(`OFF_CONTROL, 32'h2);
        outs(2'b10);
        wr(`OFF_SOFT_PENDING, 32'h0);
        outs(2'b00);
        for (l = 0; l < 16; l++) begin
            seed = lfsr(seed);
            pol = seed[0];
            pa = l < 8 ? `OFF_PEND_LOW : `OFF_PEND_HIGH;
            both(`OFF_MASK_HIGH, {16{seed[1]}});
            both(`OFF_POL_HIGH, {16{pol}});
            wr(`OFF_CONTROL, 32'h3);
            line(l, !pol);
            both(`OFF_PEND_HIGH, 16'h0);
            line(l, pol);
            rd(pa, 32'h1 << (l % 8));
            outs({2{seed[1]}});
            both(`OFF_PEND_HIGH, ~(16'h1 << l));
            rd(pa, 32'h0);
            line(l, !pol);
            rd(pa, 32'h0);
        end
        both(`OFF_MASK_HIGH, 16'hFFFF);
        both(`OFF_POL_HIGH, 16'hFFFF);
        line(3, 1'b0);
        line(5, 1'b0);
        both(`OFF_PEND_HIGH, 16'h0);
        line(3, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_CONTROL, 32'(c));
            outs(exp_out(2'(c), 1'b1));
        end
        line(5, 1'b1);
        wr(`OFF_CONTROL, 32'h2);
        l = irq_edges;
        wr(`OFF_PEND_LOW, 32'h000000F7);
        repeat (4) @(posedge pclk);
        `CHK("irq_edges", l + 1, irq_edges)
        seed = lfsr(seed);
        l = int'(seed[3:0]);
        pa = l < 8 ? `OFF_PEND_LOW : `OFF_PEND_HIGH;
        mm = 16'h1 << l;
        line(l, 1'b0);
        both(`OFF_MASK_HIGH, mm);
        both(`OFF_PEND_HIGH, 16'h0);
        wseq(1, 4'h1, 2'b11);
        rd(`OFF_CONTROL, 32'h7);
        wr(`OFF_SOFT_PENDING, 32'h1);
        outs(2'b10);
        wr(`OFF_SOFT_PENDING, 32'h0);
        wseq(1, 4'h0, 2'b11);
        rd(`OFF_CONTROL, 32'h3);
        wseq(1, 4'h1, 2'b11);
        `CHK("stop_request", 1'b1, stop_request)
        `CHK("stop_entries", 1, stop_entries)
        rd(`OFF_CONTROL, 32'h7);
        @(posedge pclk);
        wake_lines[l] <= 1'b1;
        @(posedge pclk);
        `CHK("async_wake", 1'b1, async_wake)
        repeat (5) @(posedge pclk);
        `CHK("stop_request", 1'b0, stop_request)
        rd(`OFF_CONTROL, 32'h3);
        stop3(2'b11, 1'b0);
        both(`OFF_PEND_HIGH, 16'h0);
        stop3(2'b10, 1'b0);
        both(`OFF_MASK_HIGH, 16'h0);
        stop3(2'b11, 1'b0);
        both(`OFF_MASK_HIGH, mm);
        wseq(4, 4'h9, 2'b11);
        `CHK("stop_request", 1'b0, stop_request)
        rd(`OFF_CONTROL, 32'h7);
        wseq(2, 4'h0, 2'b11);
        line(l, 1'b0);
        wseq(2, 4'h2, 2'b11);
        line(l, 1'b1);
        wseq(1, 4'h1, 2'b11);
        `CHK("stop_request", 1'b0, stop_request)
        rd(`OFF_CONTROL, 32'h3);
        rd(pa, 32'h1 << (l % 8));
        test_done();
    end
endmodule
